// ---- inc/ebmc_pkg.sv ----
// Constants and types of the emulator breakpoint and memory map controller
//
// Function
// - Three 15-bit breakpoint registers that the host loads before a run.
// - Address and status compared each run cycle; a match stops the run.
// - Match output is asserted while running whenever any armed breakpoint matches.
// - Break-on-match can be disabled; match output keeps being produced.
// - At end of emulation, trace, processor state and status go to host.
// - Host commands taken; results and completion go to a parameter block.
// - Program replacement RAM is 4K as sixteen 256-byte pages, full speed.
// - One 256-byte data page can stand in for external data memory.
// - Host map steers each 256-byte segment to replacement or user memory.
// - Software selects emulation clock between internal 6 MHz and 3 MHz.
// - Internal clock may yield to a TTL clock that the target supplies.
// - Enable command arms the loaded breakpoint registers.
// - Go command starts real-time emulation with its breakpoint options.
// - Step command runs one instruction, then halts and dumps registers.
// - Interrupt command raises an interrupt to the emulated processor.
// - Each instruction cycle recorded into a 255 x 44 trace RAM.
// - Resettable counter counts instruction cycles during emulation.
package ebmc_pkg;
   localparam int BP_COUNT = 3;
   localparam int BP_W = 15;
   localparam int ADDR_W = 12;
   localparam int STAT_W = 3;
   localparam int TRACE_W = 44;
   localparam int TRACE_DEPTH = 255;
   localparam int TPTR_W = 8;
   localparam int PAGE_W = 8;
   localparam int PROG_PAGES = 16;
   localparam int CYC_W = 16;
   localparam int DUMP_W = 8;
   localparam int DUMP_WORDS = 32;
   localparam int DPTR_W = 5;
   // Command opcodes
   localparam logic [3:0] CMD_ENABLE = 4'h1;
   localparam logic [3:0] CMD_GO = 4'h2;
   localparam logic [3:0] CMD_STEP = 4'h3;
   localparam logic [3:0] CMD_INTR = 4'h4;
   localparam logic [3:0] CMD_LOAD_BP = 4'h5;
   localparam logic [3:0] CMD_MAP = 4'h6;
   localparam logic [3:0] CMD_CLOCK = 4'h7;
   localparam logic [3:0] CMD_HWRESET = 4'h8;
   localparam logic [3:0] CMD_HALT = 4'h9;
   // Clock select codes
   localparam logic [1:0] CLK_6MHZ = 2'h0;
   localparam logic [1:0] CLK_3MHZ = 2'h1;
   localparam logic [1:0] CLK_EXT = 2'h2;
   // Divide of 20 MHz toward 6 and 3 MHz emulation clock strobes
   localparam int SYS_MHZ = 20;
   localparam int DIV6 = SYS_MHZ / 6;
   localparam int DIV3 = SYS_MHZ / 3;
   localparam logic [3:0] DIV6_CNT = 4'(DIV6 - 1);
   localparam logic [3:0] DIV3_CNT = 4'(DIV3 - 1);
   // Status codes in parameter block
   localparam logic [7:0] ST_IDLE = 8'h00;
   localparam logic [7:0] ST_DONE = 8'h01;
   localparam logic [7:0] ST_BREAK = 8'h02;
   localparam logic [7:0] ST_HALTED = 8'h03;
   localparam logic [7:0] ST_BADCMD = 8'h0e;
   typedef enum logic [2:0] {
      EBMC_IDLE = 3'b000,
      EBMC_RUN = 3'b001,
      EBMC_STEP = 3'b100,
      EBMC_DUMP = 3'b011,
      EBMC_TRACE = 3'b010
   } ebmc_state_t;
endpackage

// ---- rtl/ebmc_ctrl.sv ----
// Emulator controller: breakpoints, memory map, clock select, trace and dump
`timescale 1ns/1ps
`default_nettype none
module ebmc_ctrl (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Host command port
   input wire logic cmd_valid_i,
   input wire logic [3:0] cmd_op_i,
   input wire logic [15:0] cmd_arg_i,
   input wire logic [1:0] cmd_sel_i,
   output logic cmd_done_o,
   output logic [7:0] status_o,
   // Host block write-back
   output logic blk_we_o,
   output logic [8:0] blk_addr_o,
   output logic [ebmc_pkg::TRACE_W-1:0] blk_data_o,
   // Emulated processor
   input wire logic [ebmc_pkg::ADDR_W-1:0] emu_addr_i,
   input wire logic [ebmc_pkg::STAT_W-1:0] emu_stat_i,
   input wire logic emu_prog_i,
   input wire logic emu_inst_i,
   input wire logic [ebmc_pkg::TRACE_W-1:0] emu_trace_i,
   input wire logic [ebmc_pkg::DUMP_W-1:0] emu_dump_i,
   input wire logic ext_clk_i,
   output logic emu_run_o,
   output logic emu_clk_o,
   output logic emu_irq_o,
   output logic [ebmc_pkg::DPTR_W-1:0] dump_sel_o,
   // Memory steering and instruments
   output logic use_repl_o,
   output logic repl_data_o,
   output logic [ebmc_pkg::CYC_W-1:0] cycles_o,
   output logic match_o
);
   ebmc_pkg::ebmc_state_t state;
   logic [ebmc_pkg::BP_W-1:0] bp [ebmc_pkg::BP_COUNT];
   logic [ebmc_pkg::BP_COUNT-1:0] bp_loaded;
   logic armed;
   logic brk_en;
   logic [ebmc_pkg::PROG_PAGES-1:0] map_prog;
   logic map_data;
   logic [1:0] clk_sel;
   logic [3:0] div_cnt;
   logic [2:0] ext_sync;
   logic ext_level;
   logic [ebmc_pkg::TRACE_W-1:0] trace_ram [ebmc_pkg::TRACE_DEPTH];
   logic [ebmc_pkg::TPTR_W-1:0] tptr;
   logic [ebmc_pkg::TPTR_W-1:0] tcount;
   logic [ebmc_pkg::TPTR_W-1:0] rd_idx;
   logic [ebmc_pkg::DPTR_W-1:0] dptr;
   logic [ebmc_pkg::BP_COUNT-1:0] hit;
   logic any_hit;
   logic cmd;
   logic inst_tick;
   logic dump_last;
   logic trace_last;

   // ----------------------------------------------------------------
   // Breakpoint comparators
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < ebmc_pkg::BP_COUNT; g++) begin : g_bp
         assign hit[g] = armed && bp_loaded[g]
            && bp[g] == {emu_stat_i, emu_addr_i};
      end
   endgenerate
   assign any_hit = |hit;
   assign cmd = ce_i && cmd_valid_i;
   assign inst_tick = ce_i && emu_inst_i && emu_run_o;
   assign dump_last = dptr == ebmc_pkg::DPTR_W'(ebmc_pkg::DUMP_WORDS - 1);
   assign trace_last = rd_idx == tcount;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         match_o <= 1'b0;
      end else if (ce_i) begin
         match_o <= any_hit && emu_run_o;
      end
   end

   // ----------------------------------------------------------------
   // Host-loaded setup: breakpoints, arming, map, clock
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < ebmc_pkg::BP_COUNT; i++) begin
            bp[i] <= '0;
         end
         bp_loaded <= '0;
         armed <= 1'b0;
         brk_en <= 1'b1;
         map_prog <= '0;
         map_data <= 1'b0;
         clk_sel <= ebmc_pkg::CLK_6MHZ;
      end else if (cmd && state == ebmc_pkg::EBMC_IDLE) begin
         unique case (cmd_op_i)
            ebmc_pkg::CMD_LOAD_BP: begin
               if (cmd_sel_i != 2'h3) begin
                  bp[cmd_sel_i] <= cmd_arg_i[ebmc_pkg::BP_W-1:0];
                  bp_loaded[cmd_sel_i] <= 1'b1;
               end
            end
            ebmc_pkg::CMD_ENABLE: begin
               armed <= 1'b1;
            end
            ebmc_pkg::CMD_GO: begin
               brk_en <= ~cmd_arg_i[0];
            end
            ebmc_pkg::CMD_MAP: begin
               map_prog <= cmd_arg_i;
               map_data <= cmd_sel_i[0];
            end
            ebmc_pkg::CMD_CLOCK: begin
               clk_sel <= cmd_arg_i[1:0];
            end
            ebmc_pkg::CMD_HWRESET: begin
               armed <= 1'b0;
               bp_loaded <= '0;
               map_prog <= '0;
               map_data <= 1'b0;
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Memory steering, full speed (registered one cycle)
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         use_repl_o <= 1'b0;
         repl_data_o <= 1'b0;
      end else if (ce_i) begin
         use_repl_o <= emu_prog_i
            ? map_prog[emu_addr_i[ebmc_pkg::ADDR_W-1:ebmc_pkg::PAGE_W]]
            : map_data;
         repl_data_o <= ~emu_prog_i && map_data;
      end
   end

   // ----------------------------------------------------------------
   // Emulation clock: internal dividers or synchronised target clock
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_sync <= '0;
         ext_level <= 1'b0;
      end else if (ce_i) begin
         ext_sync <= {ext_sync[1:0], ext_clk_i};
         if (ext_sync[1] == ext_sync[2]) begin
            ext_level <= ext_sync[2];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_cnt <= '0;
         emu_clk_o <= 1'b0;
      end else if (ce_i) begin
         if (clk_sel == ebmc_pkg::CLK_EXT) begin
            div_cnt <= '0;
            emu_clk_o <= ext_level;
         end else if (div_cnt == ((clk_sel == ebmc_pkg::CLK_3MHZ)
               ? ebmc_pkg::DIV3_CNT : ebmc_pkg::DIV6_CNT)) begin
            div_cnt <= '0;
            emu_clk_o <= ~emu_clk_o;
         end else begin
            div_cnt <= div_cnt + 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Control sequence: run, step, register dump, trace upload
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ebmc_pkg::EBMC_IDLE;
         emu_run_o <= 1'b0;
         cmd_done_o <= 1'b0;
         status_o <= ebmc_pkg::ST_IDLE;
         dptr <= '0;
         rd_idx <= '0;
      end else if (ce_i) begin
         cmd_done_o <= 1'b0;
         unique case (state)
            ebmc_pkg::EBMC_IDLE: begin
               if (cmd_valid_i) begin
                  cmd_done_o <= 1'b1;
                  status_o <= ebmc_pkg::ST_DONE;
                  if (cmd_op_i == ebmc_pkg::CMD_GO) begin
                     cmd_done_o <= 1'b0;
                     emu_run_o <= 1'b1;
                     state <= ebmc_pkg::EBMC_RUN;
                  end else if (cmd_op_i == ebmc_pkg::CMD_STEP) begin
                     cmd_done_o <= 1'b0;
                     emu_run_o <= 1'b1;
                     state <= ebmc_pkg::EBMC_STEP;
                  end else if (cmd_op_i == 4'h0 || cmd_op_i > 4'h9) begin
                     status_o <= ebmc_pkg::ST_BADCMD;
                  end
               end
            end
            ebmc_pkg::EBMC_RUN: begin
               if (any_hit && brk_en) begin
                  emu_run_o <= 1'b0;
                  status_o <= ebmc_pkg::ST_BREAK;
                  dptr <= '0;
                  state <= ebmc_pkg::EBMC_DUMP;
               end else if (cmd_valid_i && cmd_op_i == ebmc_pkg::CMD_HALT) begin
                  emu_run_o <= 1'b0;
                  status_o <= ebmc_pkg::ST_HALTED;
                  dptr <= '0;
                  state <= ebmc_pkg::EBMC_DUMP;
               end
            end
            ebmc_pkg::EBMC_STEP: begin
               if (emu_inst_i) begin
                  emu_run_o <= 1'b0;
                  status_o <= ebmc_pkg::ST_DONE;
                  dptr <= '0;
                  state <= ebmc_pkg::EBMC_DUMP;
               end
            end
            ebmc_pkg::EBMC_DUMP: begin
               dptr <= dptr + 1'b1;
               if (dump_last) begin
                  rd_idx <= '0;
                  state <= ebmc_pkg::EBMC_TRACE;
               end
            end
            ebmc_pkg::EBMC_TRACE: begin
               rd_idx <= rd_idx + 1'b1;
               if (trace_last) begin
                  cmd_done_o <= 1'b1;
                  state <= ebmc_pkg::EBMC_IDLE;
               end
            end
            default: begin
               state <= ebmc_pkg::EBMC_IDLE;
               emu_run_o <= 1'b0;
            end
         endcase
      end
   end

   // Interrupt request to the emulated processor, held until next instruction
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         emu_irq_o <= 1'b0;
      end else if (ce_i) begin
         if (cmd_valid_i && cmd_op_i == ebmc_pkg::CMD_INTR) begin
            emu_irq_o <= 1'b1;
         end else if (inst_tick) begin
            emu_irq_o <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Trace RAM and cycle counter
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (inst_tick) begin
         trace_ram[tptr] <= emu_trace_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tptr <= '0;
         tcount <= '0;
         cycles_o <= '0;
      end else if (cmd && cmd_op_i == ebmc_pkg::CMD_HWRESET
            && state == ebmc_pkg::EBMC_IDLE) begin
         tptr <= '0;
         tcount <= '0;
         cycles_o <= '0;
      end else if (inst_tick) begin
         cycles_o <= cycles_o + 1'b1;
         tptr <= (tptr == ebmc_pkg::TPTR_W'(ebmc_pkg::TRACE_DEPTH - 1))
            ? '0 : tptr + 1'b1;
         if (tcount != ebmc_pkg::TPTR_W'(ebmc_pkg::TRACE_DEPTH)) begin
            tcount <= tcount + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Write-back to host block: dump words then trace entries
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         blk_we_o <= 1'b0;
         blk_addr_o <= '0;
         blk_data_o <= '0;
         dump_sel_o <= '0;
      end else if (ce_i) begin
         // Select the word that the next dump edge captures
         dump_sel_o <= (state == ebmc_pkg::EBMC_DUMP)
            ? dptr + 5'h1 : '0;
         blk_we_o <= 1'b0;
         if (state == ebmc_pkg::EBMC_DUMP) begin
            blk_we_o <= 1'b1;
            blk_addr_o <= {4'h0, dptr};
            blk_data_o <= {36'h0, emu_dump_i};
         end else if (state == ebmc_pkg::EBMC_TRACE && !trace_last) begin
            blk_we_o <= 1'b1;
            blk_addr_o <= 9'h020 + {1'b0, rd_idx};
            blk_data_o <= trace_ram[rd_idx];
         end
      end
   end
endmodule
`default_nettype wire

// ---- sim/ebmc_asserts.sv ----
// Concurrent checks of the emulator breakpoint controller
`timescale 1ns/1ps
`default_nettype none
module ebmc_asserts (
   // Clock and host commands
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic cmd_valid_i,
   input wire logic [3:0] cmd_op_i,
   input wire logic [15:0] cmd_arg_i,
   input wire logic [1:0] cmd_sel_i,
   input wire logic cmd_done_o,
   // Processor and instruments
   input wire logic [ebmc_pkg::ADDR_W-1:0] emu_addr_i,
   input wire logic [ebmc_pkg::STAT_W-1:0] emu_stat_i,
   input wire logic emu_inst_i,
   input wire logic emu_run_o,
   input wire logic emu_irq_o,
   input wire logic blk_we_o,
   input wire logic [8:0] blk_addr_o,
   input wire logic [ebmc_pkg::CYC_W-1:0] cycles_o,
   input wire logic match_o
);
   logic [14:0] bp [3];
   logic [2:0] ld;
   logic arm, nobrk, take, idle, hit, go_mode;
   assign take = cmd_valid_i && ce_i;
   assign idle = !emu_run_o && !blk_we_o;
   assign hit = (ld[0] && {emu_stat_i, emu_addr_i} == bp[0]) ||
      (ld[1] && {emu_stat_i, emu_addr_i} == bp[1]) ||
      (ld[2] && {emu_stat_i, emu_addr_i} == bp[2]);
   // Shadow of the loaded breakpoints and the break mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ld <= 3'h0;
         arm <= 1'b0;
         nobrk <= 1'b0;
         go_mode <= 1'b0;
      end else if (take) begin
         if (cmd_op_i == ebmc_pkg::CMD_LOAD_BP && cmd_sel_i != 2'h3) begin
            bp[cmd_sel_i] <= cmd_arg_i[14:0];
            ld[cmd_sel_i] <= 1'b1;
         end
         if (cmd_op_i == ebmc_pkg::CMD_ENABLE) arm <= 1'b1;
         if (cmd_op_i == ebmc_pkg::CMD_HWRESET) begin
            arm <= 1'b0;
            ld <= 3'h0;
         end
         // Remember whether the current run came from go or from step
         if (idle && cmd_op_i == ebmc_pkg::CMD_GO) go_mode <= 1'b1;
         if (idle && cmd_op_i == ebmc_pkg::CMD_STEP) go_mode <= 1'b0;
         if (cmd_op_i == ebmc_pkg::CMD_GO) nobrk <= cmd_arg_i[0];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_go_taken;
      take && cmd_op_i == ebmc_pkg::CMD_GO && idle;
   endsequence
   sequence s_dump_start;
      blk_addr_o == 9'h0 ##1 blk_we_o && blk_addr_o == 9'h1;
   endsequence
   chk_setup_done: assert property (take && idle &&
      cmd_op_i == ebmc_pkg::CMD_ENABLE |=> cmd_done_o)
      else $error("enable not acknowledged");
   chk_go_runs: assert property (s_go_taken |=> emu_run_o)
      else $error("go did not start emulation");
   chk_match_out: assert property (emu_run_o && arm && hit |=> match_o)
      else $error("match output missing");
   chk_break_stops: assert property (go_mode && arm && hit &&
      emu_run_o && !nobrk |=> !emu_run_o)
      else $error("match did not end emulation");
   chk_nobrk_runs: assert property (go_mode && match_o && nobrk &&
      emu_run_o && !cmd_valid_i |=> emu_run_o)
      else $error("break taken while disabled");
   chk_irq_set: assert property (take && idle &&
      cmd_op_i == ebmc_pkg::CMD_INTR |-> ##[1:2] emu_irq_o)
      else $error("interrupt request not raised");
   chk_irq_clear: assert property (emu_irq_o && emu_inst_i &&
      emu_run_o |=> !emu_irq_o)
      else $error("interrupt request not taken");
   chk_count_inst: assert property (emu_run_o && emu_inst_i &&
      !cmd_valid_i |=> cycles_o == $past(cycles_o) + 16'h1)
      else $error("instruction not counted");
   chk_idle_hold: assert property (!emu_run_o && !cmd_valid_i |=>
      !emu_run_o && $stable(cycles_o))
      else $error("halted state changed");
   chk_dump_start: assert property ($rose(blk_we_o) |-> s_dump_start)
      else $error("upload does not start at word 0");
endmodule
bind ebmc_ctrl ebmc_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .ce_i(ce_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
   .cmd_arg_i(cmd_arg_i), .cmd_sel_i(cmd_sel_i), .cmd_done_o(cmd_done_o),
   .emu_addr_i(emu_addr_i), .emu_stat_i(emu_stat_i),
   .emu_inst_i(emu_inst_i), .emu_run_o(emu_run_o), .emu_irq_o(emu_irq_o),
   .blk_we_o(blk_we_o), .blk_addr_o(blk_addr_o), .cycles_o(cycles_o),
   .match_o(match_o));
`default_nettype wire

// ---- sim/ebmc_proc_model.sv ----
// Emulated processor and target clock seen from the controller
`timescale 1ns/1ps
`default_nettype none
module ebmc_proc_model (
   // Clock and controls
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [11:0] start_i,
   input wire logic run_i,
   input wire logic [ebmc_pkg::DPTR_W-1:0] sel_i,
   // Processor pins
   output logic [ebmc_pkg::ADDR_W-1:0] addr_o,
   output logic [ebmc_pkg::STAT_W-1:0] stat_o,
   output logic inst_o,
   output logic [ebmc_pkg::TRACE_W-1:0] trace_o,
   output logic [ebmc_pkg::DUMP_W-1:0] dump_o,
   output logic ext_clk_o
);
   logic [11:0] pc;
   logic [2:0] cnt;
   logic [2:0] ediv;
   // One instruction every six clocks while running
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         pc <= start_i;
         cnt <= 3'h0;
         inst_o <= 1'b0;
      end else begin
         cnt <= (cnt == 3'h5) ? 3'h0 : cnt + 3'h1;
         inst_o <= (cnt == 3'h5);
         if (cnt == 3'h5) pc <= pc + 12'h1;
      end
   end
   // Free-running target clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ediv <= 3'h0;
         ext_clk_o <= 1'b0;
      end else begin
         ediv <= (ediv == 3'h6) ? 3'h0 : ediv + 3'h1;
         if (ediv == 3'h6) ext_clk_o <= !ext_clk_o;
      end
   end
   // A halted processor drives the inverted PC and status 2 on its bus
   assign addr_o = run_i ? pc : ~pc;
   assign stat_o = run_i ? 3'h5 : 3'h2;
   assign trace_o = {32'h0, pc};
   assign dump_o = {3'h6, sel_i};
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench of the emulator breakpoint controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [11:0] START = 12'h120;
   logic clk_i, rst_i, cmd_valid_i, prog, done, run, irq, repl, rdata, mt;
   logic ext, eclk, inst, blk_we;
   logic [3:0] cmd_op_i;
   logic [15:0] cmd_arg_i, cyc, c0;
   logic [1:0] cmd_sel_i;
   logic [7:0] status, dump;
   logic [8:0] blk_addr;
   logic [43:0] blk_data, trace;
   logic [11:0] addr;
   logic [2:0] stat;
   logic [4:0] dsel;
   int n_errors = 0, n_tests = 0, n_cyc = 0, n_trace = 0, words, lat;
   logic m_seen, r_seen;
   ebmc_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_arg_i(cmd_arg_i),
      .cmd_sel_i(cmd_sel_i), .cmd_done_o(done), .status_o(status),
      .blk_we_o(blk_we), .blk_addr_o(blk_addr), .blk_data_o(blk_data),
      .emu_addr_i(addr), .emu_stat_i(stat), .emu_prog_i(prog),
      .emu_inst_i(inst), .emu_trace_i(trace), .emu_dump_i(dump),
      .ext_clk_i(ext), .emu_run_o(run), .emu_clk_o(eclk), .emu_irq_o(irq),
      .dump_sel_o(dsel), .use_repl_o(repl), .repl_data_o(rdata),
      .cycles_o(cyc), .match_o(mt));
   ebmc_proc_model i_proc (.clk_i(clk_i), .rst_i(rst_i), .start_i(START),
      .run_i(run), .sel_i(dsel), .addr_o(addr), .stat_o(stat),
      .inst_o(inst), .trace_o(trace), .dump_o(dump), .ext_clk_o(ext));
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   always @(negedge clk_i) begin
      if (mt === 1'b1) m_seen = 1'b1;
      if (repl === 1'b1) r_seen = 1'b1;
   end
   always @(posedge clk_i) begin
      n_cyc++;
      if (n_cyc == 5000) begin
         n_errors++;
         wrap_up;
      end
   end
   //----------------------------------------
   // Shared tasks
   //----------------------------------------
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic send(logic [3:0] op, logic [15:0] arg, logic [1:0] sel);
      @(negedge clk_i);
      cmd_valid_i = 1'b1;
      cmd_op_i = op;
      cmd_arg_i = arg;
      cmd_sel_i = sel;
      @(negedge clk_i);
      cmd_valid_i = 1'b0;
   endtask
   task automatic wait_done;
      words = 0;
      for (lat = 0; lat < 600 && done !== 1'b1; lat++) begin
         if (blk_we === 1'b1) begin
            chk("block addr", 16'(words), {7'h0, blk_addr});
            if (words < 32) chk("dump word", {8'h0, 3'h6, 5'(words)}, {8'h0, blk_data[7:0]});
            else if (words == 32)
               chk("trace", {4'h0, START + 12'h1}, blk_data[15:0]);
            words++;
         end
         @(negedge clk_i);
      end
      chk("done", 16'h1, {15'h0, done});
   endtask
   task automatic t_setup;
      send(4'hf, 16'h0, 2'h0);
      repeat (2) @(negedge clk_i);
      chk("bad op status", 16'h0e, {8'h0, status});
      send(ebmc_pkg::CMD_HWRESET, 16'h0, 2'h0);
      wait_done;
      chk("cycles cleared", 16'h0, cyc);
      for (int k = 0; k < 3; k++) begin
         send(ebmc_pkg::CMD_LOAD_BP, {4'h5, START + 12'(k + 3)}, 2'(k));
         wait_done;
         chk("load latency", 16'h0, 16'(lat));
      end
      send(ebmc_pkg::CMD_ENABLE, 16'h0, 2'h0);
      wait_done;
   endtask
   task automatic t_run(logic [3:0] op, int n, logic [7:0] st);
      c0 = cyc;
      n_trace += n;
      m_seen = 1'b0;
      r_seen = 1'b0;
      send(op, 16'h0, 2'h0);
      wait_done;
      chk("status", {8'h0, st}, {8'h0, status});
      chk("instructions", 16'(n), cyc - c0);
      chk("words", 16'(32 + n_trace), 16'(words));
      chk("user memory", 16'h0, {15'h0, r_seen});
      repeat (20) @(negedge clk_i);
      chk("halted", 16'h0, {15'h0, run});
   endtask
   task automatic t_irq;
      send(ebmc_pkg::CMD_INTR, 16'h0, 2'h0);
      @(negedge clk_i);
      chk("irq raised", 16'h1, {15'h0, irq});
      send(ebmc_pkg::CMD_GO, 16'h1, 2'h0);
      repeat (10) @(negedge clk_i);
      chk("irq taken", 16'h0, {15'h0, irq});
      send(ebmc_pkg::CMD_HALT, 16'h0, 2'h0);
      wait_done;
   endtask
   task automatic t_clocks;
      int exp [3] = '{20, 10, 9};
      int tog;
      logic prev;
      for (int c = 0; c < 3; c++) begin
         send(ebmc_pkg::CMD_CLOCK, 16'(c), 2'h0);
         wait_done;
         m_seen = 1'b0;
         send(ebmc_pkg::CMD_GO, 16'h1, 2'h0);
         tog = 0;
         prev = eclk;
         repeat (60) begin
            @(negedge clk_i);
            if (eclk !== prev) tog++;
            prev = eclk;
         end
         chk("clock toggles", 16'(exp[c]), 16'(tog + ((tog < exp[c]) ? 1 : (tog > exp[c]) ? -1 : 0)));
         chk("still running", 16'h1, {15'h0, run});
         chk("match seen", 16'h1, {15'h0, m_seen});
         send(ebmc_pkg::CMD_HALT, 16'h0, 2'h0);
         wait_done;
         chk("halt status", 16'h03, {8'h0, status});
      end
   endtask
   task automatic t_map;
      prog = 1'b1;
      send(ebmc_pkg::CMD_MAP, 16'h1 << (~START >> 8), 2'h1);
      wait_done;
      @(negedge clk_i);
      chk("program page", 16'h1, {15'h0, repl});
      chk("no data page", 16'h0, {15'h0, rdata});
      prog = 1'b0;
      @(negedge clk_i);
      chk("data page", 16'h3, {14'h0, repl, rdata});
      send(ebmc_pkg::CMD_HWRESET, 16'h0, 2'h0);
      wait_done;
      @(negedge clk_i);
      chk("map cleared", 16'h0, {14'h0, repl, rdata});
      prog = 1'b1;
   endtask
   task automatic wrap_up;
      if (n_errors == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      rst_i = 1'b1;
      cmd_valid_i = 1'b0;
      cmd_op_i = 4'h0;
      cmd_arg_i = 16'h0;
      cmd_sel_i = 2'h0;
      prog = 1'b1;
      repeat (8) @(negedge clk_i);
      rst_i = 1'b0;
      chk("status at reset", 16'h0, {8'h0, status});
      t_setup;
      t_run(ebmc_pkg::CMD_GO, 3, ebmc_pkg::ST_BREAK);
      chk("match on break", 16'h1, {15'h0, m_seen});
      t_run(ebmc_pkg::CMD_STEP, 1, ebmc_pkg::ST_DONE);
      t_irq;
      t_clocks;
      t_map;
      wrap_up;
   end
endmodule
`default_nettype wire
